// ---- design/usbx_consts.svh ----
// Purpose: offsets, field positions, reset values and counts of the usb signal register bank
// Assumes: byte addresses on a 32-bit Avalon-MM bus, 8-bit registers in the low lane
// Notes:   definitions only
`ifndef USBX_CONSTS_SVH
`define USBX_CONSTS_SVH

`define USBX_ADDR_W        24
`define USBX_OFS_MAIN      24'h1C_0094
`define USBX_OFS_XCVR      24'h1C_0100
`define USBX_OFS_OBSERVE   24'h1C_0104
`define USBX_OFS_OVERRIDE  24'h1C_0108

`define USBX_REG_RESET     8'h00
`define USBX_XCVR_WMASK    8'hC3
`define USBX_OVR_WMASK     8'h1C
`define USBX_MAIN_WMASK    8'h08

`define USBX_XCVR_SLEEP    7
`define USBX_XCVR_PDN      6
`define USBX_CLKSEL_HI     1
`define USBX_CLKSEL_LO     0

`define USBX_OBS_PU        7
`define USBX_OBS_PD        6
`define USBX_OBS_RSVD      5
`define USBX_OBS_MPD       4

`define USBX_OVR_PUEN      4
`define USBX_OVR_CABLE     3
`define USBX_OVR_BUSPWR    2
`define USBX_OVR_SESS_GOOD 1
`define USBX_OVR_SESS_OVER 0

`define USBX_MAIN_HOST     3

`define USBX_FRAME_W       14
`define USBX_FRAME_BITS    14'h2EE0
`define USBX_EP_ZERO_ONLY  16'h0001
`define USBX_EP_ALL        16'hFFFF
`define USBX_XFER_ALL      4'hF
`define USBX_SYNC_W        4

`endif

// ---- design/usbx_pkg.sv ----
// Purpose: shared types of the usb signal register bank
// Assumes: nothing beyond the constants header
// Notes:   states and clock select codes
package usbx_pkg;

  typedef enum logic [0:0]
  {
    USBX_PERIPH = 1'b0,
    USBX_HOST   = 1'b1
  } usbx_mode_t;

  typedef enum logic [1:0]
  {
    USBX_CLK_ALT  = 2'b00,
    USBX_CLK_XTAL = 2'b01,
    USBX_CLK_RSVD = 2'b10,
    USBX_CLK_PLL  = 2'b11
  } usbx_clk_t;

endpackage

// ---- design/usbx_signal_regs.sv ----
// Purpose: transceiver control, pull observation, otg signal override and host mode selection
// Assumes: one 250 MHz clock; session and pin-override inputs arrive from outside and are synced
// Notes:   i_bit_tick is a one-cycle strobe per usb bit time from the bit-rate generator
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "usbx_consts.svh"

// Notes on behaviour
// R1 - sleep bit 7 holds the transceiver suspended; zero runs it normally.
// R2 - bit 6 switches weak pulldowns on both data lines.
// R3 - clock select 00 alternate pin, 01 crystal, 11 system pll, 10 reserved.
// R4 - observe bits 7, 6, 4 show plus pullup, plus pulldown, minus pulldown.
// R5 - observe bit 5 always reads zero.
// R6 - in peripheral mode override bit 4 enables the plus-line pullup.
// R7 - without an assigned pin, override bit 3 drives the cable identity input.
// R8 - without an assigned pin, override bit 2 drives bus-power-valid.
// R9 - override bit 1 reads back session valid.
// R10 - override bit 0 reads back session end.
// R11 - host mode enable bit in main control selects host, else peripheral.
// R12 - peripheral or host, never both at once.
// R13 - in host mode only endpoint zero is used.
// R14 - software disables all other endpoints while host mode is on.
// R15 - host mode allows bulk, isochronous, interrupt and control transfers.
// R16 - host mode enables pulldowns, drops pullup, starts start-of-frame generation.
// R17 - entering host mode loads the frame counter with 12000 bit times.
// R18 - reserved bits read zero, ignore writes; implemented bits reset to zero.
module usbx_signal_regs
  import usbx_pkg::*;
#(
  parameter int ADDR_W     = `USBX_ADDR_W,
  parameter int FRAME_BITS = `USBX_FRAME_BITS
)
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [3:0]        i_avs_byteenable,
  input  wire logic [31:0]       i_avs_writedata,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // pins from outside the clock domain
  input  wire logic              i_session_good,
  input  wire logic              i_session_over,
  input  wire logic              i_cable_kind_pin,
  input  wire logic              i_bus_power_good_pin,
  // pin function assignment and bit tick, same clock
  input  wire logic              i_cable_pin_assigned,
  input  wire logic              i_bus_power_pin_assigned,
  input  wire logic              i_bit_tick,
  // transceiver controls
  output logic                   o_transceiver_sleep,
  output logic                   o_weak_pulldown_enable,
  output logic                   o_sel_alternate_clock_pin,
  output logic                   o_sel_crystal_input_pin,
  output logic                   o_sel_system_pll_clock,
  // controller signals
  output logic                   o_plus_pullup,
  output logic                   o_plus_pulldown,
  output logic                   o_minus_pulldown,
  output logic                   o_cable_kind,
  output logic                   o_bus_power_good,
  output logic                   o_host_mode,
  output logic                   o_peripheral_mode,
  output logic      [15:0]       o_endpoint_allow,
  output logic      [3:0]        o_xfer_type_allow,
  output logic                   o_sof_pulse
);

  if (ADDR_W < 21 || FRAME_BITS < 2 || FRAME_BITS >= (1 << `USBX_FRAME_W))
  begin : g_bad_param
    $error("usbx_signal_regs: unsupported ADDR_W or FRAME_BITS");
  end

  localparam logic [`USBX_FRAME_W-1:0] FRAME_LOAD = `USBX_FRAME_W'(FRAME_BITS);

  // every check below runs on the system clock and rests while reset is high
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  logic                    ack_r;
  logic [7:0]              xcvr_r;
  logic [7:0]              ovr_r;
  logic [7:0]              main_r;
  logic [31:0]             rdata_r;
  logic [`USBX_SYNC_W-1:0] meta_r;
  logic [`USBX_SYNC_W-1:0] sync_r;
  usbx_mode_t              mode_r;
  usbx_mode_t              mode_nxt;
  logic [`USBX_FRAME_W-1:0] frame_r;
  logic [`USBX_FRAME_W-1:0] frame_nxt;
  logic                    sof_nxt;
  logic                    pull_r;
  logic                    pd_r;
  logic                    cable_r;
  logic                    buspwr_r;
  logic [15:0]             ep_r;

  // bus decode: one wait cycle, so every access ends on the second edge
  wire req      = i_avs_read | i_avs_write;
  wire wr_fire  = i_avs_write & ack_r;
  wire rd_fire  = i_avs_read & ack_r;
  wire lane0    = i_avs_byteenable[0];
  wire hit_main = i_avs_address == ADDR_W'(`USBX_OFS_MAIN);
  wire hit_xcvr = i_avs_address == ADDR_W'(`USBX_OFS_XCVR);
  wire hit_obs  = i_avs_address == ADDR_W'(`USBX_OFS_OBSERVE);
  wire hit_ovr  = i_avs_address == ADDR_W'(`USBX_OFS_OVERRIDE);
  wire [7:0] wbyte = i_avs_writedata[7:0];

  wire sess_good_s = sync_r[0];
  wire sess_over_s = sync_r[1];
  wire cable_pin_s = sync_r[2];
  wire buspwr_pin_s = sync_r[3];

  wire [7:0] obs_val = {pull_r, pd_r, 1'b0, pd_r, 4'h0}; // see R4 see R5
  wire [7:0] ovr_val = {ovr_r[7:2], sess_good_s, sess_over_s}; // see R9 see R10
  wire [7:0] rd_byte = hit_xcvr ? xcvr_r :
                       hit_obs  ? obs_val :
                       hit_ovr  ? ovr_val :
                       hit_main ? main_r : `USBX_REG_RESET; // see R18

  assign o_avs_waitrequest = req & ~ack_r;
  assign o_avs_readdata    = rdata_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (i_avs_read & ~ack_r)
        rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // writes land only on implemented bits; reserved bits stay zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      xcvr_r <= `USBX_REG_RESET; // see R18
      ovr_r  <= `USBX_REG_RESET;
      main_r <= `USBX_REG_RESET;
    end
    else if (wr_fire & lane0)
    begin
      if (hit_xcvr)
        xcvr_r <= wbyte & `USBX_XCVR_WMASK; // see R18
      else if (hit_ovr)
        ovr_r <= wbyte & `USBX_OVR_WMASK;
      else if (hit_main)
        main_r <= wbyte & `USBX_MAIN_WMASK;
    end
  end

  // two-stage synchroniser for all asynchronous inputs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {i_bus_power_good_pin, i_cable_kind_pin, i_session_over, i_session_good};
      sync_r <= meta_r;
    end
  end

  assign o_transceiver_sleep    = xcvr_r[`USBX_XCVR_SLEEP]; // see R1
  assign o_weak_pulldown_enable = xcvr_r[`USBX_XCVR_PDN]; // see R2

  wire [1:0] clk_code = xcvr_r[`USBX_CLKSEL_HI:`USBX_CLKSEL_LO];
  // reserved code selects nothing rather than guessing a source
  assign o_sel_alternate_clock_pin = clk_code == USBX_CLK_ALT; // see R3
  assign o_sel_crystal_input_pin   = clk_code == USBX_CLK_XTAL; // see R3
  assign o_sel_system_pll_clock    = clk_code == USBX_CLK_PLL; // see R3

  // mode machine
  always_comb
  begin
    case (mode_r)
      USBX_PERIPH: mode_nxt = main_r[`USBX_MAIN_HOST] ? USBX_HOST : USBX_PERIPH; // see R11
      USBX_HOST:   mode_nxt = main_r[`USBX_MAIN_HOST] ? USBX_HOST : USBX_PERIPH;
      default:     mode_nxt = USBX_PERIPH;
    endcase
  end

  // frame counter counts bit times; reload on entry and on every expiry
  always_comb
  begin
    frame_nxt = frame_r;
    sof_nxt   = 1'b0;
    if (mode_r == USBX_PERIPH && mode_nxt == USBX_HOST)
      frame_nxt = FRAME_LOAD; // see R17
    else if (mode_r == USBX_HOST && i_bit_tick)
    begin
      if (frame_r <= `USBX_FRAME_W'(1))
      begin
        frame_nxt = FRAME_LOAD;
        sof_nxt   = 1'b1; // see R16
      end
      else
        frame_nxt = frame_r - `USBX_FRAME_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      mode_r      <= USBX_PERIPH;
      frame_r     <= '0;
      o_sof_pulse <= 1'b0;
    end
    else
    begin
      mode_r      <= mode_nxt;
      frame_r     <= frame_nxt;
      o_sof_pulse <= sof_nxt;
    end
  end

  // controller-side signals, all registered
  wire host_nxt = mode_nxt == USBX_HOST;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      pull_r   <= 1'b0;
      pd_r     <= 1'b0;
      cable_r  <= 1'b0;
      buspwr_r <= 1'b0;
      ep_r     <= `USBX_EP_ALL;
    end
    else
    begin
      pull_r   <= ~host_nxt & ovr_r[`USBX_OVR_PUEN]; // see R6 see R16
      pd_r     <= host_nxt; // see R16
      cable_r  <= i_cable_pin_assigned ? cable_pin_s : ovr_r[`USBX_OVR_CABLE]; // see R7
      buspwr_r <= i_bus_power_pin_assigned ? buspwr_pin_s : ovr_r[`USBX_OVR_BUSPWR]; // see R8
      ep_r     <= host_nxt ? `USBX_EP_ZERO_ONLY : `USBX_EP_ALL; // see R13
    end
  end

  assign o_plus_pullup     = pull_r;
  assign o_plus_pulldown   = pd_r;
  assign o_minus_pulldown  = pd_r;
  assign o_cable_kind      = cable_r;
  assign o_bus_power_good  = buspwr_r;
  assign o_host_mode       = mode_r == USBX_HOST; // see R12
  assign o_peripheral_mode = mode_r == USBX_PERIPH; // see R12
  assign o_endpoint_allow  = ep_r;
  // the packet engine honours these in both modes; none is barred in host mode
  assign o_xfer_type_allow = `USBX_XFER_ALL; // see R15

  // checks

  sequence xcvr_write;
    wr_fire && lane0 && hit_xcvr;
  endsequence

  sequence main_host_write;
    wr_fire && lane0 && hit_main && i_avs_writedata[`USBX_MAIN_HOST];
  endsequence

  sequence host_entry;
    $rose(o_host_mode);
  endsequence

  sleep_follow_a: assert property ( // see R1
    xcvr_write |=> o_transceiver_sleep == $past(i_avs_writedata[`USBX_XCVR_SLEEP]))
    else $error("sleep output does not follow written bit");

  pulldown_follow_a: assert property ( // see R2
    xcvr_write |=> o_weak_pulldown_enable == $past(i_avs_writedata[`USBX_XCVR_PDN]))
    else $error("weak pulldown output does not follow written bit");

  clock_select_a: assert property ( // see R3
    xcvr_write |=> ($past(i_avs_writedata[1:0]) == 2'b10) ==
      !(o_sel_alternate_clock_pin || o_sel_crystal_input_pin || o_sel_system_pll_clock))
    else $error("clock select decode wrong");

  observe_pulls_a: assert property ( // see R4
    rd_fire && hit_obs |-> o_avs_readdata[`USBX_OBS_PU] == $past(o_plus_pullup) &&
      o_avs_readdata[`USBX_OBS_PD] == $past(o_plus_pulldown) &&
      o_avs_readdata[`USBX_OBS_MPD] == $past(o_minus_pulldown))
    else $error("observe register does not show pull state");

  observe_zero_a: assert property ( // see R5
    rd_fire && hit_obs |-> o_avs_readdata[`USBX_OBS_RSVD] == 1'b0)
    else $error("observe reserved bit not zero");

  cable_override_a: assert property ( // see R7
    !i_cable_pin_assigned ##1 !i_cable_pin_assigned |->
      o_cable_kind == $past(ovr_r[`USBX_OVR_CABLE]))
    else $error("cable identity not driven by override bit");

  bus_power_override_a: assert property ( // see R8
    !i_bus_power_pin_assigned ##1 !i_bus_power_pin_assigned |->
      o_bus_power_good == $past(ovr_r[`USBX_OVR_BUSPWR]))
    else $error("bus power valid not driven by override bit");

  session_read_a: assert property ( // see R9 see R10
    rd_fire && hit_ovr |->
      o_avs_readdata[`USBX_OVR_SESS_GOOD] == $past(sess_good_s) &&
      o_avs_readdata[`USBX_OVR_SESS_OVER] == $past(sess_over_s) &&
      o_avs_readdata[7:5] == 3'b000)
    else $error("session bits read back wrong");

  host_enter_a: assert property ( // see R11
    main_host_write ##1 main_r[`USBX_MAIN_HOST] |-> ##1 o_host_mode)
    else $error("host mode not entered after enable write");

  mode_exclusive_a: assert property ( // see R12
    o_host_mode != o_peripheral_mode &&
      (o_host_mode == $past(main_r[`USBX_MAIN_HOST]) || $past(i_reset)))
    else $error("host and peripheral mode both or neither");

  host_pulls_a: assert property ( // see R13 see R16
    o_host_mode [*2] |-> o_plus_pulldown && !o_plus_pullup &&
      o_endpoint_allow == `USBX_EP_ZERO_ONLY)
    else $error("host mode pulls or endpoint mask wrong");

  frame_load_a: assert property ( // see R17
    host_entry |-> frame_r == FRAME_LOAD && !o_sof_pulse)
    else $error("frame counter not loaded on host entry");

endmodule // usbx_signal_regs

// ---- sim/usbx_far_end.sv ----
// Purpose: far-side stand-in for session, pin levels and bit ticks
// Assumes: the bench sets levels through set_lines
// Notes:   tick divider shortened so frames stay short
`timescale 1ns/100ps
module usbx_far_end
#(
  parameter int TICK_DIV = 3
)
(
  // clock
  input  wire logic i_clk,
  // lines toward the block
  output logic      o_session_good,
  output logic      o_session_over,
  output logic      o_cable_pin,
  output logic      o_bus_power_pin,
  output logic      o_bit_tick
);
  int div_cnt = 0;

  initial
  begin
    {o_session_good, o_session_over, o_cable_pin, o_bus_power_pin} = 4'h0;
    o_bit_tick = 1'b0;
  end

  // levels move only after an edge, like the real sensing logic
  task automatic set_lines(input logic [3:0] v);
    @(posedge i_clk);
    {o_session_good, o_session_over, o_cable_pin, o_bus_power_pin} <= v;
  endtask

  always @(posedge i_clk)
  begin
    div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
    o_bit_tick <= (div_cnt == 0);
  end
endmodule // usbx_far_end

// ---- sim/test_usbx_signal_regs.sv ----
// Purpose: self-checking bench of the usb signal register bank
// Assumes: one wait state per access, short frame parameter
// Notes:   expectations come from the register model below
`timescale 1ns/100ps
`include "usbx_consts.svh"
module test_usbx_signal_regs;
  import usbx_pkg::*;
  localparam int FB = 4;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, cas = 1'b0, bas = 1'b0;
  logic [23:0] adr = '0;
  logic [3:0]  be = '0;
  logic [31:0] wd = '0, rdata, q;
  logic        wt, sg, so, cp, bp, tick, sleep, wpd, s_alt, s_xt, s_pll;
  logic        pu, ppd, mpd, cab, bpw, host, per, sof;
  logic [15:0] epa;
  logic [3:0]  xfa;
  logic [7:0]  mdl [logic [23:0]];
  logic [23:0] regs [3] = '{`USBX_OFS_XCVR, `USBX_OFS_OVERRIDE, `USBX_OFS_MAIN};
  logic [23:0] offs [5] = '{`USBX_OFS_MAIN, `USBX_OFS_XCVR, `USBX_OFS_OBSERVE,
                            `USBX_OFS_OVERRIDE, 24'h1C_010C};
  int          error_cnt = 0, tests_run = 0, cyc = 0, n;
  logic [7:0]  d;

  always #2 clk = ~clk;

  usbx_signal_regs #(.FRAME_BITS(FB)) i_usbx_signal_regs (
    .i_sys_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_byteenable(be), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_session_good(sg),
    .i_session_over(so), .i_cable_kind_pin(cp), .i_bus_power_good_pin(bp),
    .i_cable_pin_assigned(cas), .i_bus_power_pin_assigned(bas), .i_bit_tick(tick),
    .o_transceiver_sleep(sleep), .o_weak_pulldown_enable(wpd),
    .o_sel_alternate_clock_pin(s_alt), .o_sel_crystal_input_pin(s_xt),
    .o_sel_system_pll_clock(s_pll), .o_plus_pullup(pu), .o_plus_pulldown(ppd),
    .o_minus_pulldown(mpd), .o_cable_kind(cab), .o_bus_power_good(bpw),
    .o_host_mode(host), .o_peripheral_mode(per), .o_endpoint_allow(epa),
    .o_xfer_type_allow(xfa), .o_sof_pulse(sof));

  usbx_far_end i_usbx_far_end (
    .i_clk(clk), .o_session_good(sg), .o_session_over(so), .o_cable_pin(cp),
    .o_bus_power_pin(bp), .o_bit_tick(tick));

  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [23:0] a, input logic [7:0] dv,
                     input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, dv};
    be <= b;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic [7:0] msk(input logic [23:0] a);
    case (a)
      `USBX_OFS_XCVR:     msk = `USBX_XCVR_WMASK;
      `USBX_OFS_OVERRIDE: msk = `USBX_OVR_WMASK;
      default:            msk = `USBX_MAIN_WMASK;
    endcase
  endfunction

  function automatic logic [31:0] exp_rd(input logic [23:0] a);
    logic       h;
    logic [7:0] o;
    h = mdl[`USBX_OFS_MAIN][3];
    o = mdl[`USBX_OFS_OVERRIDE];
    if (a == `USBX_OFS_OBSERVE)
      exp_rd = {24'h0, ~h & o[4], h, 1'b0, h, 4'h0};
    else if (a == `USBX_OFS_OVERRIDE)
      exp_rd = {24'h0, o | {6'h0, sg, so}};
    else
      exp_rd = mdl.exists(a) ? {24'h0, mdl[a]} : 32'h0000_0000;
  endfunction

  task automatic rdall;
    foreach (offs[k])
    begin
      bus(1'b0, offs[k], 8'h00, 4'h1);
      chk(q, exp_rd(offs[k]));
    end
  endtask

  task automatic outs;
    logic       h;
    logic [7:0] x, o;
    repeat (3) @(posedge clk);
    h = mdl[`USBX_OFS_MAIN][3];
    x = mdl[`USBX_OFS_XCVR];
    o = mdl[`USBX_OFS_OVERRIDE];
    chk({sleep, wpd}, {x[7], x[6]});
    chk({s_alt, s_xt, s_pll}, {x[1:0] == 2'b00, x[1:0] == 2'b01, x[1:0] == 2'b11});
    chk({pu, ppd, mpd, host, per}, {~h & o[4], h, h, h, ~h});
    chk({cab, bpw}, {cas ? cp : o[3], bas ? bp : o[2]});
    chk({epa, xfa}, {h ? 16'h0001 : 16'hFFFF, 4'hF});
  endtask

  initial
  begin
    foreach (regs[k]) mdl[regs[k]] = 8'h00;
    void'($urandom(32'h4415c1b8));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    outs;
    rdall;
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      d[1:0] = 2'(i >> 2);
      i_usbx_far_end.set_lines(4'($urandom));
      cas <= 1'($urandom);
      bas <= 1'($urandom);
      // a write without lane 0 must leave the register alone
      bus(1'b1, regs[i % 3], d, (i == 7) ? 4'hE : 4'h1);
      if (i != 7)
        mdl[regs[i % 3]] = d & msk(regs[i % 3]);
      bus(1'b1, 24'h1C_010C, d, 4'h1);
      outs;
      rdall;
    end
    bus(1'b1, `USBX_OFS_MAIN, 8'h08, 4'h1);
    mdl[`USBX_OFS_MAIN] = 8'h08;
    outs;
    while (sof !== 1'b1) @(posedge clk);
    n = 0;
    do
    begin
      @(posedge clk);
      n += int'(tick);
    end
    while (sof !== 1'b1);
    chk(n, FB);
    conclude;
  end
endmodule // test_usbx_signal_regs
